// File: rtl/pnv_defs.vh
// constants for the potentiometer nonvolatile store and serial command block
`ifndef PNV_DEFS_VH
`define PNV_DEFS_VH
// opcodes (frame bits 15:12)
`define PNV_OP_NOP 4'h0
`define PNV_OP_RECALL1 4'h1
`define PNV_OP_SAVE 4'h2
`define PNV_OP_USER_STORE 4'h3
`define PNV_OP_RSHIFT1 4'h4
`define PNV_OP_RSHIFT_ALL 4'h5
`define PNV_OP_DEC1 4'h6
`define PNV_OP_DEC_ALL 4'h7
`define PNV_OP_RECALL_ALL 4'h8
`define PNV_OP_NV_READ 4'h9
`define PNV_OP_WIPER_READ 4'ha
`define PNV_OP_WIPER_WRITE 4'hb
`define PNV_OP_LSHIFT1 4'hc
`define PNV_OP_LSHIFT_ALL 4'hd
`define PNV_OP_INC1 4'he
`define PNV_OP_INC_ALL 4'hf
// frame field positions
`define PNV_OPC_HI 15
`define PNV_OPC_LO 12
`define PNV_ADR_HI 11
`define PNV_ADR_LO 8
`define PNV_FRAME_BITS 16
// store locations and wiper register addresses
`define PNV_LOC_WIPER1 4'h0
`define PNV_LOC_WIPER2 4'h1
`define PNV_LOC_SPARE_FIRST 4'h2
`define PNV_LOC_SPARE_LAST 4'hf
`define PNV_WREG_WIPER1 1'b0
`define PNV_WREG_WIPER2 1'b1
// values
`define PNV_MIDSCALE 8'h80
`define PNV_FULLSCALE 8'hff
`define PNV_STORE_RESET 8'h80
`define PNV_TAPS 256
`endif

// File: rtl/pnv_store_mem.v
// sixteen-byte nonvolatile store with registered read port
`timescale 1ns/10ps
`include "pnv_defs.vh"
module pnv_store_mem (
  input wire clk, // block clock
  input wire rst, // async reset, active high
  input wire wr_en, // write strobe
  input wire [3:0] wr_addr, // write location
  input wire [7:0] wr_data, // write byte
  input wire [3:0] rd_addr, // read location
  output reg [7:0] rd_data, // registered read byte
  output reg [7:0] preset1, // location 0, read continuously
  output reg [7:0] preset2 // location 1, read continuously
);
  reg [7:0] mem [0:15];
  integer i;

  // storage cells; reset stands in for the factory-programmed content
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 16; i = i + 1) begin
        mem[i] <= `PNV_STORE_RESET;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read and preset taps come out of registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
      preset1 <= `PNV_STORE_RESET;
      preset2 <= `PNV_STORE_RESET;
    end else begin
      rd_data <= mem[rd_addr];
      preset1 <= mem[`PNV_LOC_WIPER1];
      preset2 <= mem[`PNV_LOC_WIPER2];
    end
  end
endmodule

// File: rtl/pnv_tap_decode.v
// one-hot tap switch decode for one wiper channel
`timescale 1ns/10ps
module pnv_tap_decode (
  input wire clk, // block clock
  input wire rst, // async reset, active high
  input wire [7:0] wiper, // wiper position value
  output reg [255:0] tap_on, // exactly one tap switch on
  output reg terminal_a_end_switch, // end switch, always on
  output reg terminal_b_end_switch // end switch, always on
);
  // registered so the switch lines never glitch through two taps
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tap_on <= 256'h1;
      terminal_a_end_switch <= 1'b1;
      terminal_b_end_switch <= 1'b1;
    end else begin
      tap_on <= 256'h1 << wiper;
      terminal_a_end_switch <= 1'b1;
      terminal_b_end_switch <= 1'b1;
    end
  end
endmodule

// File: rtl/pnv_top.v
// serial command decode, wiper registers, store access and recall
`timescale 1ns/10ps
`include "pnv_defs.vh"
module pnv_top (
  input wire ref_clk, // 10 MHz block clock
  input wire rst, // async reset, active high (power-on recall)
  input wire sclk, // serial shift clock pin
  input wire cs_n, // chip select pin, active low
  input wire sdi, // serial data in pin
  output reg sdo_q, // serial data out
  output reg [7:0] wiper1_q, // wiper 1 position register
  output reg [7:0] wiper2_q, // wiper 2 position register
  output reg read_mode_q, // elevated read-mode power state
  output reg [255:0] tap1_q, // wiper 1 tap switches
  output reg [255:0] tap2_q, // wiper 2 tap switches
  output reg end_sw_a_q, // terminal a end switches on
  output reg end_sw_b_q // terminal b end switches on
);
  localparam ST_BOOT = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_RECALL = 3'b100;

  reg [2:0] state_q, state_d;
  reg [1:0] sclk_s, cs_s, sdi_s;
  reg sclk_p, cs_p;
  reg [15:0] shreg_q;
  reg [4:0] nbits_q;
  reg recall_sel_q; // 1: both wipers, 0: one wiper
  reg recall_adr_q;
  reg mem_we;
  reg [3:0] mem_wa;
  reg [7:0] mem_wd;
  reg [3:0] mem_ra;
  reg pend_read_q;
  wire [7:0] mem_rd, pre1, pre2;
  wire [255:0] t1, t2;
  wire a1, b1, a2, b2;
  wire sclk_rise, sclk_fall, cs_rise, cs_fall;
  wire [3:0] opc, adr;
  wire [7:0] dat;

  // right shift: exact for even codes, low bit dropped for odd
  function [7:0] rshift;
    input [7:0] v;
    begin
      rshift = {1'b0, v[7:1]};
    end
  endfunction

  // left shift with zero to one and clamp at midscale or above
  function [7:0] lshift;
    input [7:0] v;
    begin
      if (v == 8'h00) begin
        lshift = 8'h01;
      end else if (v >= `PNV_MIDSCALE) begin
        lshift = `PNV_FULLSCALE;
      end else begin
        lshift = {v[6:0], 1'b0};
      end
    end
  endfunction

  function [7:0] incr;
    input [7:0] v;
    begin
      incr = (v == `PNV_FULLSCALE) ? v : v + 8'h01;
    end
  endfunction

  function [7:0] decr;
    input [7:0] v;
    begin
      decr = (v == 8'h00) ? v : v - 8'h01;
    end
  endfunction

  // pins are foreign to ref_clk: two flops before any logic looks
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_s <= 2'b00;
      cs_s <= 2'b11;
      sdi_s <= 2'b00;
      sclk_p <= 1'b0;
      cs_p <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], sclk};
      cs_s <= {cs_s[0], cs_n};
      sdi_s <= {sdi_s[0], sdi};
      sclk_p <= sclk_s[1];
      cs_p <= cs_s[1];
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_p;
  assign sclk_fall = ~sclk_s[1] & sclk_p;
  assign cs_rise = cs_s[1] & ~cs_p;
  assign cs_fall = ~cs_s[1] & cs_p;
  assign opc = shreg_q[`PNV_OPC_HI:`PNV_OPC_LO];
  assign adr = shreg_q[`PNV_ADR_HI:`PNV_ADR_LO];
  assign dat = shreg_q[7:0];

  pnv_store_mem u_mem (
    .clk(ref_clk),
    .rst(rst),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(mem_ra),
    .rd_data(mem_rd),
    .preset1(pre1),
    .preset2(pre2)
  );

  pnv_tap_decode u_tap1 (
    .clk(ref_clk),
    .rst(rst),
    .wiper(wiper1_q),
    .tap_on(t1),
    .terminal_a_end_switch(a1),
    .terminal_b_end_switch(b1)
  );

  pnv_tap_decode u_tap2 (
    .clk(ref_clk),
    .rst(rst),
    .wiper(wiper2_q),
    .tap_on(t2),
    .terminal_a_end_switch(a2),
    .terminal_b_end_switch(b2)
  );

  // store write steering only at frame end; the read port address follows the frame address field always
  always @* begin
    mem_we = 1'b0;
    mem_wa = adr;
    mem_wd = dat;
    mem_ra = adr;
    // a short frame must not touch the store either
    if (state_q == ST_RUN && cs_rise && nbits_q == 5'h10) begin
      case (opc)
        `PNV_OP_SAVE: begin
          mem_we = 1'b1;
          mem_wa = {3'b000, adr[0]};
          mem_wd = adr[0] ? wiper2_q : wiper1_q;
        end
        `PNV_OP_USER_STORE: begin
          mem_we = 1'b1;
        end
        default: begin
          mem_we = 1'b0;
        end
      endcase
    end
  end

  // boot recall waits one cycle for the preset taps to settle
  always @* begin
    case (state_q)
      ST_BOOT: state_d = ST_RECALL;
      ST_RUN: begin
        if (cs_rise && nbits_q == 5'h10 &&
            (opc == `PNV_OP_RECALL1 || opc == `PNV_OP_RECALL_ALL)) begin
          state_d = ST_RECALL;
        end else begin
          state_d = ST_RUN;
        end
      end
      ST_RECALL: state_d = ST_RUN;
      default: state_d = ST_BOOT;
    endcase
  end

  // command execution and serial register
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_BOOT;
      shreg_q <= 16'h0000;
      nbits_q <= 5'h00;
      wiper1_q <= 8'h00;
      wiper2_q <= 8'h00;
      read_mode_q <= 1'b0;
      recall_sel_q <= 1'b1;
      recall_adr_q <= 1'b0;
      pend_read_q <= 1'b0;
      sdo_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_read_q <= 1'b0;
      if (cs_fall) begin
        nbits_q <= 5'h00;
      end
      if (!cs_s[1] && sclk_rise) begin
        shreg_q <= {shreg_q[14:0], sdi_s[1]};
        if (nbits_q != 5'h10) begin
          nbits_q <= nbits_q + 5'h01;
        end
      end
      if (!cs_s[1] && sclk_fall) begin
        sdo_q <= shreg_q[15];
      end
      if (state_q == ST_RECALL) begin
        if (recall_sel_q || !recall_adr_q) begin
          wiper1_q <= pre1;
        end
        if (recall_sel_q || recall_adr_q) begin
          wiper2_q <= pre2;
        end
      end
      if (pend_read_q) begin
        shreg_q <= {shreg_q[15:8], mem_rd};
      end
      // short frames are dropped as incomplete
      if (state_q == ST_RUN && cs_rise && nbits_q == 5'h10) begin
        case (opc)
          `PNV_OP_NOP: read_mode_q <= 1'b0;
          `PNV_OP_RECALL1: begin
            recall_sel_q <= 1'b0;
            recall_adr_q <= adr[0];
            read_mode_q <= 1'b1;
          end
          `PNV_OP_RECALL_ALL: recall_sel_q <= 1'b1;
          `PNV_OP_NV_READ: pend_read_q <= 1'b1;
          `PNV_OP_WIPER_READ: begin
            shreg_q <= {shreg_q[15:8],
              adr[0] ? wiper2_q : wiper1_q};
          end
          `PNV_OP_WIPER_WRITE: begin
            if (adr[0] == `PNV_WREG_WIPER1) begin
              wiper1_q <= dat;
            end else begin
              wiper2_q <= dat;
            end
          end
          `PNV_OP_RSHIFT1: begin
            if (adr[0]) wiper2_q <= rshift(wiper2_q);
            else wiper1_q <= rshift(wiper1_q);
          end
          `PNV_OP_RSHIFT_ALL: begin
            wiper1_q <= rshift(wiper1_q);
            wiper2_q <= rshift(wiper2_q);
          end
          `PNV_OP_LSHIFT1: begin
            if (adr[0]) wiper2_q <= lshift(wiper2_q);
            else wiper1_q <= lshift(wiper1_q);
          end
          `PNV_OP_LSHIFT_ALL: begin
            wiper1_q <= lshift(wiper1_q);
            wiper2_q <= lshift(wiper2_q);
          end
          `PNV_OP_DEC1: begin
            if (adr[0]) wiper2_q <= decr(wiper2_q);
            else wiper1_q <= decr(wiper1_q);
          end
          `PNV_OP_DEC_ALL: begin
            wiper1_q <= decr(wiper1_q);
            wiper2_q <= decr(wiper2_q);
          end
          `PNV_OP_INC1: begin
            if (adr[0]) wiper2_q <= incr(wiper2_q);
            else wiper1_q <= incr(wiper1_q);
          end
          `PNV_OP_INC_ALL: begin
            wiper1_q <= incr(wiper1_q);
            wiper2_q <= incr(wiper2_q);
          end
          default: read_mode_q <= read_mode_q;
        endcase
      end
    end
  end

  // switch outputs re-registered so every top output is a flop
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tap1_q <= 256'h1;
      tap2_q <= 256'h1;
      end_sw_a_q <= 1'b1;
      end_sw_b_q <= 1'b1;
    end else begin
      tap1_q <= t1;
      tap2_q <= t2;
      end_sw_a_q <= a1 & a2;
      end_sw_b_q <= b1 & b2;
    end
  end
endmodule

// File: sim/pnv_checker_assertions.sv
// assertion checker for the potentiometer store block
`timescale 1ns/10ps
module pnv_checker (
  input wire ref_clk, // block clock
  input wire rst, // async reset, active high
  input wire sclk, // serial clock pin
  input wire cs_n, // chip select, active low
  input wire sdi, // serial data in
  input wire sdo_q, // serial data out
  input wire [7:0] wiper1_q, // wiper 1 position
  input wire [7:0] wiper2_q, // wiper 2 position
  input wire read_mode_q, // read-mode power state
  input wire [255:0] tap1_q, // wiper 1 taps
  input wire [255:0] tap2_q, // wiper 2 taps
  input wire end_sw_a_q, // terminal a end switch
  input wire end_sw_b_q // terminal b end switch
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_end_switches: assert property (end_sw_a_q && end_sw_b_q)
    else $error("end switch off");
  chk_tap1_onehot: assert property ($onehot(tap1_q))
    else $error("tap1 not one-hot");
  chk_tap2_onehot: assert property ($onehot(tap2_q))
    else $error("tap2 not one-hot");
  // taps trail the wiper by two edges, so wait for a settled value
  chk_tap1_match: assert property (
    $stable(wiper1_q)[*3] |-> tap1_q[wiper1_q])
    else $error("tap1 does not follow wiper1");
  chk_tap2_match: assert property (
    $stable(wiper2_q)[*3] |-> tap2_q[wiper2_q])
    else $error("tap2 does not follow wiper2");
  // a wiper may only move once chip select has risen and settled
  chk_wiper1_at_cs: assert property (
    $changed(wiper1_q) |-> cs_n && $past(cs_n, 2))
    else $error("wiper1 moved inside a frame");
  chk_wiper2_at_cs: assert property (
    $changed(wiper2_q) |-> cs_n && $past(cs_n, 2))
    else $error("wiper2 moved inside a frame");
  chk_mode_enter: assert property (
    $rose(read_mode_q) |-> cs_n && $past(cs_n, 2))
    else $error("read mode entered inside a frame");
  chk_mode_leave: assert property (
    $fell(read_mode_q) |-> cs_n && $past(cs_n, 2))
    else $error("read mode left inside a frame");
  cov_mode: cover property ($rose(read_mode_q));
  cov_wiper1: cover property ($changed(wiper1_q));
  cov_wiper2: cover property ($changed(wiper2_q));
endmodule
bind pnv_top pnv_checker i_pnv_checker (.ref_clk, .rst, .sclk, .cs_n, .sdi,
  .sdo_q, .wiper1_q, .wiper2_q, .read_mode_q, .tap1_q, .tap2_q,
  .end_sw_a_q, .end_sw_b_q);

// File: sim/pnv_host.sv
// host model sending serial command frames to the block
`timescale 1ns/10ps
module pnv_host (
  input wire ref_clk, // bench clock, paces the link
  output reg sclk, // serial clock, stands low between frames
  output reg cs_n, // chip select, active low
  output reg sdi, // serial data, msb first
  input wire sdo_q // serial data from the block
);
  integer i;
  initial begin
    sclk <= 1'b0;
    cs_n <= 1'b1;
    sdi <= 1'b0;
  end
  // one 16-bit frame, 800 ns per bit, pins moved only on ref_clk edges;
  // sdo is taken four edges after each fall, once the block has updated it
  task xfer(input [15:0] f, output [15:0] r);
    begin
      cs_n <= 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        sdi <= f[i];
        repeat (2) @(posedge ref_clk);
        if (i < 15) begin
          r = {r[14:0], sdo_q};
        end
        sclk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sclk <= 1'b0;
        repeat (2) @(posedge ref_clk);
      end
      repeat (2) @(posedge ref_clk);
      r = {r[14:0], sdo_q};
      // idle data line must not keep the last bit
      sdi <= ~f[0];
      cs_n <= 1'b1;
      repeat (15) @(posedge ref_clk);
    end
  endtask
endmodule

// File: sim/pnv_top_test.sv
// self-checking bench for the potentiometer store block
`timescale 1ns/10ps
module pnv_top_test;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  wire sclk, cs_n, sdi, sdo_q, read_mode_q, end_sw_a_q, end_sw_b_q;
  wire [7:0] wiper1_q, wiper2_q;
  wire [255:0] tap1_q, tap2_q;
  reg [15:0] rd;
  integer fails = 0;
  integer check_count = 0;
  integer cyc = 0;
  pnv_top i_pnv_top (.ref_clk, .rst, .sclk, .cs_n, .sdi, .sdo_q, .wiper1_q,
    .wiper2_q, .read_mode_q, .tap1_q, .tap2_q, .end_sw_a_q, .end_sw_b_q);
  pnv_host i_pnv_host (.ref_clk, .sclk, .cs_n, .sdi, .sdo_q);
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  // about 30 frames of 145 cycles each; the ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  task chk(input string n, input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[ERR] %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task cmd(input [3:0] op, input [3:0] a, input [7:0] d);
    i_pnv_host.xfer({op, a, d}, rd);
  endtask
  task t_power;
    begin
      chk("wiper1", 8'h80, wiper1_q);
      chk("wiper2", 8'h80, wiper2_q);
      chk("end switches", 8'h03, {6'h00, end_sw_a_q, end_sw_b_q});
      chk("tap1 mid", 8'h01, {7'h00, tap1_q[8'h80]});
      chk("tap2 mid", 8'h01, {7'h00, tap2_q[8'h80]});
      $display("t_power done");
    end
  endtask
  // spare bytes at both ends of the spare range, read back via a nop frame
  task t_user;
    begin
      cmd(4'h3, 4'h2, 8'h5a);
      cmd(4'h3, 4'hf, 8'ha5);
      cmd(4'h9, 4'h2, 8'h00);
      cmd(4'h0, 4'h0, 8'h00);
      chk("spare 1", 8'h5a, rd[8:1]);
      cmd(4'h9, 4'hf, 8'h00);
      cmd(4'h0, 4'h0, 8'h00);
      chk("spare 14", 8'ha5, rd[8:1]);
      $display("t_user done");
    end
  endtask
  task t_recall;
    begin
      cmd(4'hb, 4'h0, 8'h40);
      chk("wiper1 write", 8'h40, wiper1_q);
      cmd(4'hb, 4'h1, 8'h33);
      chk("wiper2 write", 8'h33, wiper2_q);
      cmd(4'h2, 4'h0, 8'h00);
      cmd(4'hb, 4'h0, 8'h00);
      cmd(4'h1, 4'h0, 8'h00);
      chk("recall one", 8'h40, wiper1_q);
      chk("recall one keeps 2", 8'h33, wiper2_q);
      chk("read mode on", 8'h01, {7'h00, read_mode_q});
      cmd(4'h0, 4'h0, 8'h00);
      chk("read mode off", 8'h00, {7'h00, read_mode_q});
      cmd(4'hb, 4'h0, 8'h11);
      cmd(4'h8, 4'h0, 8'h00);
      chk("recall all 1", 8'h40, wiper1_q);
      chk("recall all 2", 8'h80, wiper2_q);
      $display("t_recall done");
    end
  endtask
  // odd codes lose the low bit, even codes halve exactly
  task t_shift;
    begin
      cmd(4'hb, 4'h0, 8'h07);
      cmd(4'h4, 4'h0, 8'h00);
      chk("odd shift", 8'h03, wiper1_q);
      cmd(4'hb, 4'h1, 8'h06);
      cmd(4'h5, 4'h0, 8'h00);
      chk("even shift", 8'h03, wiper2_q);
      chk("odd shift all", 8'h01, wiper1_q);
      chk("tap1 one", 8'h01, {7'h00, tap1_q[8'h01]});
      $display("t_shift done");
    end
  endtask
  // left shift ends, saturating steps, zero right shift, wiper readback
  task t_adjust;
    begin
      cmd(4'hb, 4'h0, 8'h00);
      cmd(4'hc, 4'h0, 8'h00);
      chk("lshift zero", 8'h01, wiper1_q);
      cmd(4'hb, 4'h1, 8'h80);
      cmd(4'hd, 4'h0, 8'h00);
      chk("lshift all 1", 8'h02, wiper1_q);
      chk("lshift all 2", 8'hff, wiper2_q);
      cmd(4'he, 4'h1, 8'h00);
      chk("inc at top", 8'hff, wiper2_q);
      cmd(4'h7, 4'h0, 8'h00);
      chk("dec all 1", 8'h01, wiper1_q);
      chk("dec all 2", 8'hfe, wiper2_q);
      cmd(4'h6, 4'h0, 8'h00);
      chk("dec one", 8'h00, wiper1_q);
      cmd(4'h4, 4'h0, 8'h00);
      chk("rshift zero", 8'h00, wiper1_q);
      cmd(4'hf, 4'h0, 8'h00);
      chk("inc all 1", 8'h01, wiper1_q);
      chk("inc all 2", 8'hff, wiper2_q);
      chk("tap2 top", 8'h01, {7'h00, tap2_q[8'hff]});
      cmd(4'ha, 4'h1, 8'h00);
      cmd(4'h0, 4'h0, 8'h00);
      chk("wiper2 read", 8'hff, rd[8:1]);
      $display("t_adjust done");
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    t_power;
    t_user;
    t_recall;
    t_shift;
    t_adjust;
    end_sim;
  end
endmodule
